// ===== common/ctrl_if_defines.vh
// Purpose: Shared constants of the serial control interface block.
// Assumes: Core clock of 25 MHz; one subaddress byte per transfer.
// Notes: Processor subaddresses and default values are fixed here only.
`ifndef CTRL_IF_DEFINES_VH
`define CTRL_IF_DEFINES_VH

// Timing base.
`define CORE_CLK_KHZ       25000
`define PROC_STALL_MS      20

// Bus address pairs, write address shown; the read address is one higher.
`define DEV_ADDR_LOW       8'h86
`define DEV_ADDR_HIGH      8'h8E

// Subaddresses.
`define SUB_PROC_RD_ADDR   8'h26
`define SUB_PROC_WR_ADDR   8'h27
`define SUB_PROC_DATA      8'h28
`define SUB_PROC_BUSY      8'h29
`define SUB_LOW_POWER      8'hAA
`define SUB_OE_CTRL        8'hF2

// Field positions.
`define LOWPOW_MSB         1
`define LOWPOW_LSB         0
`define BIT_SOFT_RESET     2
`define BIT_OE_OVERRIDE    7
`define PROC_HI_MSB        3

// Byte framing.
`define BYTE_BITS          4'h8
`define HW_LAST            10'h0FF

// Reset and default values.
`define HW_DEFAULT         8'h00
`define PROC_DEFAULT       12'h000
`define LOWPOW_DEFAULT     2'h0
`define WIN_WIDTH_DEFAULT  10'h280
`define WIN_LINES_DEFAULT  9'h0F0
`define SYNC_RESET_VAL     5'h1E

`endif

// ===== src/pin_sync3.v
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to i_core_clk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps

module pin_sync3 #(
  parameter             WIDTH     = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  // Clock and reset
  input  wire             i_core_clk,
  input  wire             i_reset,
  // Pins in, filtered levels out
  input  wire [WIDTH-1:0] i_pins,
  output reg  [WIDTH-1:0] o_level
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always @(posedge i_core_clk) begin
        if (i_reset) begin
          stage1[g]  <= RESET_VAL[g];
          stage2[g]  <= RESET_VAL[g];
          stage3[g]  <= RESET_VAL[g];
          o_level[g] <= RESET_VAL[g];
        end else begin
          stage1[g] <= i_pins[g];
          stage2[g] <= stage1[g];
          stage3[g] <= stage2[g];
          // A change counts only once two stages agree, which rejects single-cycle spikes.
          if (stage2[g] == stage3[g]) begin
            o_level[g] <= stage3[g];
          end
        end
      end
    end
  endgenerate

endmodule // pin_sync3

// ===== src/i2c_control_fp_access.v
// Purpose: Serial control slave with direct registers and indirect processor RAM access.
// Assumes: SCL and SDA are open drain; the bench resolves the wires from the enables.
// Notes: Video datapath is outside; only its output enables and mode levels are here.
`timescale 1ns/10ps
`include "ctrl_if_defines.vh"

// What this block does
// - Drive gate pin level at init release picks address pair 86/87 or 8E/8F.
// - Each pair is an even write address and the next odd read address.
// - Sixteen-bit values go high byte first; every byte goes MSB first.
// - Direct registers are eight bits and act on hardware without the processor.
// - Processor RAM words are twelve bits, carried as sixteen-bit payloads.
// - SCL is held low on processor RAM subaddress accesses while the processor is busy, up to about 20 ms.
// - Reset clears every register, then loads defaults from internal tables.
// - While the init pin is asserted, every output floats.
// - Each init release re-samples the field pin to pick inactive or active setup.
// - Inactive setup floats ports and reference pins; active setup drives the reference pins, and the ports when drive gate is low or overridden.
// - After init the mode is NTSC square pixel, 640x240, both fields.
// - Inactive start keeps the line scheduler off until enabled over the bus.
// - Bit 2 of 0xAA reloads registers without re-sampling the straps.
module i2c_control_fp_access #(
  parameter              PROC_AW          = 9,
  parameter              PROC_DEPTH       = 512,
  parameter              BUSY_W           = 20,
  parameter [BUSY_W-1:0] PROC_BUSY_CYCLES = `PROC_STALL_MS * `CORE_CLK_KHZ,
  parameter [BUSY_W-1:0] PROC_FAST_CYCLES = 16
) (
  // Clock and reset
  input  wire        i_core_clk,
  input  wire        i_reset,
  // Serial control pins, open drain
  input  wire        i_scl,
  output reg         o_scl_out,
  output reg         o_scl_oe,
  input  wire        i_sda,
  output reg         o_sda_out,
  output reg         o_sda_oe,
  // Init and strap pins
  input  wire        i_hardware_init_pin_n,
  input  wire        i_port_drive_gate_n,
  input  wire        i_field_pin,
  // Processor condition
  input  wire        i_std_switching,
  // Output drive enables: ports A/B; line_ref_out, vref, field, active_video_flag,
  // pixel_clock_pin, line_locked_clock, line_locked_half_clock
  output reg  [1:0]  o_port_oe,
  output reg  [6:0]  o_ref_oe,
  // Mode and status
  output reg         o_hsync_sched_en,
  output reg         o_ntsc_square,
  output reg  [9:0]  o_win_width,
  output reg  [8:0]  o_win_lines,
  output reg         o_win_both_fields,
  output reg  [1:0]  o_low_power,
  output reg         o_oe_override,
  output reg         o_proc_busy,
  output reg         o_init_busy
);

  localparam [3:0] S_IDLE      = 4'h0;
  localparam [3:0] S_ADDR      = 4'h1;
  localparam [3:0] S_ADDR_ACK  = 4'h2;
  localparam [3:0] S_SUB       = 4'h3;
  localparam [3:0] S_SUB_ACK   = 4'h4;
  localparam [3:0] S_WDATA     = 4'h5;
  localparam [3:0] S_WDATA_ACK = 4'h6;
  localparam [3:0] S_RDATA     = 4'h7;
  localparam [3:0] S_MACK      = 4'h8;
  localparam [3:0] S_IGNORE    = 4'h9;

  localparam              INIT_W    = 10;
  localparam [INIT_W-1:0] INIT_LAST = (PROC_DEPTH > 256) ? PROC_DEPTH - 1 : 255;
  localparam [INIT_W-1:0] INIT_ONE  = 1;
  localparam [BUSY_W-1:0] BUSY_ONE  = 1;
  localparam [BUSY_W-1:0] BUSY_ZERO = 0;

  function is_proc_sub;
    input [7:0] s;
    begin
      is_proc_sub = (s == `SUB_PROC_RD_ADDR) || (s == `SUB_PROC_WR_ADDR) || (s == `SUB_PROC_DATA);
    end
  endfunction

  // Synchronised pins: {scl, sda, init_n, drive_gate_n, field}.
  wire [4:0] pins_f;
  wire       scl_f    = pins_f[4];
  wire       sda_f    = pins_f[3];
  wire       init_n_f = pins_f[2];
  wire       gate_n_f = pins_f[1];
  wire       field_f  = pins_f[0];

  pin_sync3 #(
    .WIDTH     (5),
    .RESET_VAL (`SYNC_RESET_VAL)
  ) u_pin_sync (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_pins     ({i_scl, i_sda, i_hardware_init_pin_n, i_port_drive_gate_n, i_field_pin}),
    .o_level    (pins_f)
  );

  reg              scl_d;
  reg              sda_d;
  reg              init_d;
  reg [3:0]        state;
  reg [3:0]        bitcnt;
  reg [7:0]        shift;
  reg [7:0]        tx;
  reg              rw;
  reg [7:0]        sub;
  reg              byte_idx;
  reg              nak;
  reg              addr_sel;
  reg              power_up_inactive;
  reg [7:0]        addr_hi;
  reg [3:0]        wdata_hi;
  reg [PROC_AW-1:0] proc_addr;
  reg [11:0]       proc_rdata;
  reg [BUSY_W-1:0] busy_cnt;
  reg [INIT_W-1:0] init_addr;
  reg [7:0]        rd_byte;

  reg [7:0]        hw_regs  [0:255];
  reg [11:0]       proc_ram [0:PROC_DEPTH-1];

  wire scl_rise     = scl_f & ~scl_d;
  wire scl_fall     = ~scl_f & scl_d;
  wire start_cond   = scl_f & scl_d & sda_d & ~sda_f;
  wire stop_cond    = scl_f & scl_d & ~sda_d & sda_f;
  wire init_release = init_n_f & ~init_d;
  wire busy_now     = (busy_cnt != BUSY_ZERO);
  wire [7:0] dev_addr = addr_sel ? `DEV_ADDR_HIGH : `DEV_ADDR_LOW;
  wire [7:0] hw_idx   = sub + {7'h00, byte_idx};
  wire [15:0] word16  = {addr_hi, shift};
  wire [15:0] addr16  = {{(16 - PROC_AW){1'b0}}, proc_addr};

  wire byte_end     = scl_fall & (bitcnt == `BYTE_BITS);
  wire take         = byte_end & (state == S_WDATA) & ~o_init_busy;
  wire hw_take      = take & ~is_proc_sub(sub);
  wire addr_take_lo = take & byte_idx & ((sub == `SUB_PROC_WR_ADDR) | (sub == `SUB_PROC_RD_ADDR));
  wire rd_addr_take = addr_take_lo & (sub == `SUB_PROC_RD_ADDR);
  wire data_take_lo = take & byte_idx & (sub == `SUB_PROC_DATA);
  wire busy_load    = rd_addr_take | data_take_lo;
  wire soft_req     = hw_take & (hw_idx == `SUB_LOW_POWER) & shift[`BIT_SOFT_RESET];
  wire [BUSY_W-1:0] busy_len = i_std_switching ? PROC_BUSY_CYCLES : PROC_FAST_CYCLES;

  // Holding SCL only while it is already low avoids cutting a high phase short.
  wire stall_need = is_proc_sub(sub) & busy_now & ~scl_f & (bitcnt == 4'h0) &
                    ((state == S_WDATA) | (state == S_RDATA));

  // Byte presented on a read; 16-bit values go out high byte first.
  always @* begin
    rd_byte = 8'h00;
    if (sub == `SUB_PROC_BUSY) begin
      rd_byte = {7'h00, busy_now};
    end else if (sub == `SUB_PROC_DATA) begin
      rd_byte = byte_idx ? proc_rdata[7:0] : {4'h0, proc_rdata[11:8]};
    end else if (is_proc_sub(sub)) begin
      rd_byte = byte_idx ? addr16[7:0] : addr16[15:8];
    end else begin
      rd_byte = hw_regs[hw_idx];
    end
  end

  // Register arrays: cleared to defaults by the loader, otherwise written from the bus.
  always @(posedge i_core_clk) begin
    if (o_init_busy) begin
      if (init_addr <= `HW_LAST) begin
        hw_regs[init_addr[7:0]] <= `HW_DEFAULT;
      end
      if (init_addr < PROC_DEPTH) begin
        proc_ram[init_addr[PROC_AW-1:0]] <= `PROC_DEFAULT;
      end
    end else begin
      if (hw_take) begin
        hw_regs[hw_idx] <= shift;
      end
      if (data_take_lo) begin
        proc_ram[proc_addr] <= {wdata_hi, shift};
      end
    end
  end

  always @(posedge i_core_clk) begin
    if (i_reset) begin
      scl_d             <= 1'b1;
      sda_d             <= 1'b1;
      init_d            <= 1'b1;
      state             <= S_IDLE;
      bitcnt            <= 4'h0;
      shift             <= 8'h00;
      tx                <= 8'h00;
      rw                <= 1'b0;
      sub               <= 8'h00;
      byte_idx          <= 1'b0;
      nak               <= 1'b0;
      addr_sel          <= 1'b0;
      power_up_inactive <= 1'b1;
      addr_hi           <= 8'h00;
      wdata_hi          <= 4'h0;
      proc_addr         <= {PROC_AW{1'b0}};
      proc_rdata        <= `PROC_DEFAULT;
      busy_cnt          <= BUSY_ZERO;
      init_addr         <= {INIT_W{1'b0}};
      o_init_busy       <= 1'b1;
      o_scl_out         <= 1'b0;
      o_scl_oe          <= 1'b0;
      o_sda_out         <= 1'b0;
      o_sda_oe          <= 1'b0;
      o_port_oe         <= 2'h0;
      o_ref_oe          <= 7'h00;
      o_hsync_sched_en  <= 1'b0;
      o_ntsc_square     <= 1'b0;
      o_win_width       <= 10'h000;
      o_win_lines       <= 9'h000;
      o_win_both_fields <= 1'b0;
      o_low_power       <= `LOWPOW_DEFAULT;
      o_oe_override     <= 1'b0;
      o_proc_busy       <= 1'b0;
    end else begin
      scl_d  <= scl_f;
      sda_d  <= sda_f;
      init_d <= init_n_f;

      // Processor busy window; the RAM access itself completes at once.
      if (busy_load) begin
        busy_cnt <= busy_len;
      end else if (busy_now) begin
        busy_cnt <= busy_cnt - BUSY_ONE;
      end
      o_proc_busy <= busy_now;

      // Processor address and data staging.
      if (take & ~byte_idx & is_proc_sub(sub)) begin
        addr_hi  <= shift;
        wdata_hi <= shift[`PROC_HI_MSB:0];
      end
      if (addr_take_lo) begin
        proc_addr <= word16[PROC_AW-1:0];
      end
      if (rd_addr_take) begin
        proc_rdata <= proc_ram[word16[PROC_AW-1:0]];
      end

      // Direct registers that steer the hardware at once.
      if (hw_take & (hw_idx == `SUB_LOW_POWER)) begin
        o_low_power       <= shift[`LOWPOW_MSB:`LOWPOW_LSB];
        power_up_inactive <= 1'b0;
      end
      if (hw_take & (hw_idx == `SUB_OE_CTRL)) begin
        o_oe_override <= shift[`BIT_OE_OVERRIDE];
      end

      // Straps are taken only at init release, never by the software reset.
      if (init_release) begin
        addr_sel          <= gate_n_f;
        power_up_inactive <= ~field_f;
      end

      // Default loader, started by init release or by the software reset.
      if (init_release | soft_req) begin
        o_init_busy       <= 1'b1;
        init_addr         <= {INIT_W{1'b0}};
        o_low_power       <= `LOWPOW_DEFAULT;
        o_oe_override     <= 1'b0;
        o_ntsc_square     <= 1'b0;
        o_win_both_fields <= 1'b0;
      end else if (o_init_busy) begin
        if (init_addr == INIT_LAST) begin
          o_init_busy       <= 1'b0;
          o_ntsc_square     <= 1'b1;
          o_win_width       <= `WIN_WIDTH_DEFAULT;
          o_win_lines       <= `WIN_LINES_DEFAULT;
          o_win_both_fields <= 1'b1;
        end else begin
          init_addr <= init_addr + INIT_ONE;
        end
      end

      // Output drive: low power is entered at once, not at the end of a line.
      o_ref_oe         <= {7{init_n_f & ~power_up_inactive & (o_low_power == 2'h0)}};
      o_port_oe        <= {2{init_n_f & ~power_up_inactive & (o_low_power == 2'h0) &
                             (~gate_n_f | o_oe_override)}};
      o_hsync_sched_en <= ~power_up_inactive & (o_low_power == 2'h0);
      o_scl_oe         <= stall_need & init_n_f;

      // Serial protocol engine.
      if (~init_n_f) begin
        state    <= S_IDLE;
        o_sda_oe <= 1'b0;
      end else if (start_cond) begin
        state    <= S_ADDR;
        bitcnt   <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (stop_cond) begin
        state    <= S_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        case (state)
          S_ADDR, S_SUB, S_WDATA: begin
            if (scl_rise) begin
              shift  <= {shift[6:0], sda_f};
              bitcnt <= bitcnt + 4'h1;
            end else if (byte_end) begin
              if (state == S_ADDR) begin
                if ((shift[7:1] == dev_addr[7:1]) & ~o_init_busy) begin
                  rw       <= shift[0];
                  o_sda_oe <= 1'b1;
                  state    <= S_ADDR_ACK;
                end else begin
                  state <= S_IGNORE;
                end
              end else if (state == S_SUB) begin
                sub      <= shift;
                o_sda_oe <= 1'b1;
                state    <= S_SUB_ACK;
              end else begin
                o_sda_oe <= 1'b1;
                state    <= S_WDATA_ACK;
              end
            end
          end
          S_ADDR_ACK, S_SUB_ACK, S_WDATA_ACK: begin
            if (scl_fall) begin
              o_sda_oe <= 1'b0;
              bitcnt   <= 4'h0;
              if (state == S_ADDR_ACK) begin
                byte_idx <= 1'b0;
                state    <= rw ? S_RDATA : S_SUB;
              end else if (state == S_SUB_ACK) begin
                byte_idx <= 1'b0;
                state    <= S_WDATA;
              end else if (byte_idx) begin
                state <= S_IGNORE;
              end else begin
                byte_idx <= 1'b1;
                state    <= S_WDATA;
              end
            end
          end
          S_RDATA: begin
            if ((bitcnt == 4'h0) & ~scl_f & ~stall_need) begin
              tx       <= rd_byte;
              o_sda_oe <= ~rd_byte[7];
            end else if (scl_rise) begin
              bitcnt <= bitcnt + 4'h1;
            end else if (byte_end) begin
              o_sda_oe <= 1'b0;
              state    <= S_MACK;
            end else if (scl_fall) begin
              tx       <= {tx[6:0], 1'b0};
              o_sda_oe <= ~tx[6];
            end
          end
          S_MACK: begin
            if (scl_rise) begin
              nak <= sda_f;
            end else if (scl_fall) begin
              bitcnt <= 4'h0;
              if (nak | byte_idx) begin
                state <= S_IGNORE;
              end else begin
                byte_idx <= 1'b1;
                state    <= S_RDATA;
              end
            end
          end
          S_IGNORE: begin
            o_sda_oe <= 1'b0;
          end
          default: begin
            o_sda_oe <= 1'b0;
            state    <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule // i2c_control_fp_access

// ===== sim/i2c_control_fp_access_sva.sv
// Purpose: Port-level checks of the serial control slave.
// Assumes: Only the top module's ports are visible.
// Notes: The busy bound follows the instance's long busy parameter.
`timescale 1ns/10ps

module ctrl_if_checker #(
  parameter int PROC_BUSY_CYCLES = 40
) (
  input wire logic       i_core_clk,
  input wire logic       i_reset,
  input wire logic       i_hardware_init_pin_n,
  input wire logic       i_port_drive_gate_n,
  input wire logic       o_scl_out,
  input wire logic       o_scl_oe,
  input wire logic       o_sda_out,
  input wire logic       o_sda_oe,
  input wire logic [1:0] o_port_oe,
  input wire logic [6:0] o_ref_oe,
  input wire logic       o_ntsc_square,
  input wire logic [9:0] o_win_width,
  input wire logic [8:0] o_win_lines,
  input wire logic       o_win_both_fields,
  input wire logic [1:0] o_low_power,
  input wire logic       o_oe_override,
  input wire logic       o_proc_busy,
  input wire logic       o_init_busy
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);

  int busy_len;

  always @(posedge i_core_clk) begin
    if (i_reset || !o_proc_busy) begin
      busy_len <= 0;
    end else begin
      busy_len <= busy_len + 1;
    end
  end

  init_float_a: assert property (!i_hardware_init_pin_n [*6] |->
    (o_port_oe == 2'h0 && o_ref_oe == 7'h00 && !o_scl_oe && !o_sda_oe))
    else $error("outputs driven while init pin held");
  ref_group_a: assert property ((o_ref_oe == 7'h00 || o_ref_oe == 7'h7F) &&
    (o_port_oe == 2'h0 || o_port_oe == 2'h3))
    else $error("output enables not moving as a group");
  port_gate_a: assert property ((i_port_drive_gate_n && !o_oe_override) [*8] |-> o_port_oe == 2'h0)
    else $error("data ports driven while gated");
  mode_load_a: assert property ($fell(o_init_busy) |-> ##[0:2] (o_ntsc_square && o_win_both_fields &&
    o_win_width == 10'h280 && o_win_lines == 9'h0F0))
    else $error("start mode wrong after load");
  init_quiet_a: assert property ($past(o_init_busy) && o_init_busy |-> !$rose(o_sda_oe) && !$rose(o_scl_oe))
    else $error("bus answered while loading");
  stretch_cause_a: assert property ($rose(o_scl_oe) |-> o_proc_busy)
    else $error("clock held without busy processor");
  stretch_end_a: assert property ($fell(o_proc_busy) |-> ##[0:2] !o_scl_oe)
    else $error("clock held after busy ended");
  busy_bound_a: assert property (busy_len <= PROC_BUSY_CYCLES + 2)
    else $error("processor busy too long");
  lowpow_float_a: assert property (o_low_power != 2'h0 [*2] |-> o_ref_oe == 7'h00 && o_port_oe == 2'h0)
    else $error("outputs driven in low power");
  drain_only_a: assert property (o_scl_out == 1'b0 && o_sda_out == 1'b0)
    else $error("open drain line driven high");

  cover property ($rose(o_scl_oe));
  cover property ($rose(o_oe_override));
  cover property ($fell(o_init_busy));
endmodule // ctrl_if_checker

bind i2c_control_fp_access ctrl_if_checker #(.PROC_BUSY_CYCLES(PROC_BUSY_CYCLES)) u_chk (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_hardware_init_pin_n(i_hardware_init_pin_n),
  .i_port_drive_gate_n(i_port_drive_gate_n), .o_scl_out(o_scl_out), .o_scl_oe(o_scl_oe),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .o_port_oe(o_port_oe), .o_ref_oe(o_ref_oe),
  .o_ntsc_square(o_ntsc_square), .o_win_width(o_win_width), .o_win_lines(o_win_lines),
  .o_win_both_fields(o_win_both_fields), .o_low_power(o_low_power), .o_oe_override(o_oe_override),
  .o_proc_busy(o_proc_busy), .o_init_busy(o_init_busy));

// ===== sim/i2c_master_model.sv
// Purpose: Behavioural bus master facing the serial control slave.
// Assumes: Wires are pulled up; high outputs pull them low.
// Notes: SCL stands high between frames; waits honour clock stretching.
`timescale 1ns/10ps

module i2c_master_model #(
  parameter int HALF = 8
) (
  // Clock and wire levels
  input  wire logic i_core_clk,
  input  wire logic i_scl,
  input  wire logic i_sda,
  // Pull-down requests
  output logic      o_scl_low,
  output logic      o_sda_low
);
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end

  task automatic half();
    repeat (HALF) @(posedge i_core_clk);
  endtask

  // The slave may stretch, so wait for the wire rather than a fixed time.
  task automatic rise();
    o_scl_low <= 1'b0;
    for (int k = 0; k < 5000 && i_scl !== 1'b1; k++) @(posedge i_core_clk);
  endtask

  task automatic start();
    half();
    o_sda_low <= 1'b0;
    half();
    rise();
    half();
    o_sda_low <= 1'b1;
    half();
    o_scl_low <= 1'b1;
  endtask

  task automatic stop();
    repeat (2) @(posedge i_core_clk);
    o_sda_low <= 1'b1;
    half();
    rise();
    half();
    o_sda_low <= 1'b0;
    half();
  endtask

  // SDA moves two cycles after SCL falls so no edge looks like start or stop.
  task automatic bit_io(input logic b, output logic r);
    repeat (2) @(posedge i_core_clk);
    o_sda_low <= !b;
    half();
    rise();
    half();
    r = i_sda;
    o_scl_low <= 1'b1;
  endtask

  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(last, r);
    ack = !r;
  endtask
endmodule // i2c_master_model

// ===== sim/testbench.sv
// Purpose: Self-checking bench of the serial control slave.
// Assumes: 25 MHz core clock; long processor busy shortened to 1000 cycles so one read is stretched.
// Notes: Each scenario checks its own results before it returns.
`timescale 1ns/10ps

module testbench;
  logic       core_clk = 1'b0;
  logic       reset = 1'b1;
  logic       init_n = 1'b1;
  logic       gate_n = 1'b0;
  logic       field = 1'b0;
  logic       std_sw = 1'b1;
  logic       m_scl;
  logic       m_sda;
  logic       ok;
  logic [15:0] q;
  int         num_errors = 0;
  int         comparisons = 0;
  int         stretch_cycles = 0;
  wire        scl_oe, scl_out, sda_oe, sda_out, sched, ntsc, both, ovr, pbusy, ibusy;
  wire  [1:0] port_oe, low_pow;
  wire  [6:0] ref_oe;
  wire  [9:0] width;
  wire  [8:0] lines;
  wire        scl = (scl_oe ? scl_out : 1'b1) & !m_scl;
  wire        sda = (sda_oe ? sda_out : 1'b1) & !m_sda;

  always #20 core_clk = ~core_clk;

  // Counts the cycles in which the slave holds SCL low.
  always @(posedge core_clk) begin
    if (scl_oe === 1'b1) stretch_cycles <= stretch_cycles + 1;
  end

  i2c_master_model u_master (.i_core_clk(core_clk), .i_scl(scl), .i_sda(sda), .o_scl_low(m_scl), .o_sda_low(m_sda));

  i2c_control_fp_access #(.PROC_BUSY_CYCLES(20'd1000)) u_dut (
    .i_core_clk(core_clk), .i_reset(reset), .i_scl(scl), .o_scl_out(scl_out), .o_scl_oe(scl_oe),
    .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_hardware_init_pin_n(init_n),
    .i_port_drive_gate_n(gate_n), .i_field_pin(field), .i_std_switching(std_sw), .o_port_oe(port_oe),
    .o_ref_oe(ref_oe), .o_hsync_sched_en(sched), .o_ntsc_square(ntsc), .o_win_width(width),
    .o_win_lines(lines), .o_win_both_fields(both), .o_low_power(low_pow), .o_oe_override(ovr),
    .o_proc_busy(pbusy), .o_init_busy(ibusy));

  task automatic conclude();
    if (num_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] s, input int n, input logic [15:0] d, output logic k);
    logic [7:0] b;
    logic       g;
    u_master.start();
    u_master.xfer(a, 1'b1, b, k);
    u_master.xfer(s, 1'b1, b, g);
    k &= g;
    if (n == 2) u_master.xfer(d[15:8], 1'b1, b, g);
    k &= g;
    u_master.xfer(d[7:0], 1'b1, b, g);
    k &= g;
    u_master.stop();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] s, input int n, output logic [15:0] r);
    logic [7:0] b;
    logic       g;
    r = 16'h0000;
    u_master.start();
    u_master.xfer(a, 1'b1, b, g);
    u_master.xfer(s, 1'b1, b, g);
    u_master.start();
    u_master.xfer(a | 8'h01, 1'b1, b, g);
    for (int i = n; i > 0; i--) begin
      u_master.xfer(8'hFF, i == 1, b, g);
      r = {r[7:0], b};
    end
    u_master.stop();
  endtask

  task automatic wait_init();
    // The init pin passes the synchroniser first, so the loader starts a few cycles late.
    repeat (8) @(posedge core_clk);
    for (int k = 0; k < 3000 && ibusy !== 1'b0; k++) @(posedge core_clk);
    chk({15'h0, ibusy}, 16'h0000);
  endtask

  task automatic poll_busy();
    logic [15:0] r;
    r = 16'h0001;
    for (int k = 0; k < 20 && r[0] !== 1'b0; k++) rd(8'h86, 8'h29, 1, r);
    chk({15'h0, r[0]}, 16'h0000);
  endtask

  task automatic t_defaults();
    wait_init();
    chk({6'h0, width}, 16'h0280);
    chk({7'h0, lines}, 16'h00F0);
    chk({14'h0, ntsc, both}, 16'h0003);
    chk({9'h0, ref_oe}, 16'h0000);
    chk({15'h0, sched}, 16'h0000);
  endtask

  task automatic t_addr();
    wr(8'h8E, 8'hF2, 1, 16'h0000, ok);
    chk({15'h0, ok}, 16'h0000);
    wr(8'h86, 8'hF2, 1, 16'h0000, ok);
    chk({15'h0, ok}, 16'h0001);
  endtask

  task automatic t_proc();
    poll_busy();
    wr(8'h86, 8'h27, 2, 16'h0123, ok);
    chk({15'h0, ok}, 16'h0001);
    wr(8'h86, 8'h28, 2, 16'h0ABC, ok);
    chk({14'h0, ok, pbusy}, 16'h0003);
    poll_busy();
    wr(8'h86, 8'h26, 2, 16'h0123, ok);
    rd(8'h86, 8'h28, 2, q);
    chk(q, 16'h0ABC);
    chk({15'h0, stretch_cycles != 0}, 16'h0001);
    std_sw <= 1'b0;
    wr(8'h86, 8'h28, 2, 16'h0123, ok);
    chk({14'h0, ok, pbusy}, 16'h0002);
  endtask

  task automatic t_wake();
    wr(8'h86, 8'hAA, 1, 16'h0000, ok);
    chk({15'h0, sched}, 16'h0001);
  endtask

  task automatic t_strap();
    @(posedge core_clk);
    init_n <= 1'b0;
    field <= 1'b1;
    gate_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk({9'h0, ref_oe}, 16'h0000);
    init_n <= 1'b1;
    wait_init();
    chk({9'h0, ref_oe}, 16'h007F);
    chk({14'h0, port_oe}, 16'h0000);
    wr(8'h86, 8'hF2, 1, 16'h0000, ok);
    chk({15'h0, ok}, 16'h0000);
    wr(8'h8E, 8'hF2, 1, 16'h0080, ok);
    chk({15'h0, ok}, 16'h0001);
    chk({14'h0, port_oe}, 16'h0003);
    rd(8'h8E, 8'hF2, 1, q);
    chk(q, 16'h0080);
  endtask

  task automatic t_soft();
    @(posedge core_clk);
    field <= 1'b0;
    gate_n <= 1'b0;
    wr(8'h8E, 8'hAA, 1, 16'h0001, ok);
    chk({7'h0, low_pow, ref_oe}, 16'h0080);
    wr(8'h8E, 8'hAA, 1, 16'h0004, ok);
    wait_init();
    chk({7'h0, low_pow, ref_oe}, 16'h007F);
    chk({14'h0, port_oe}, 16'h0003);
    wr(8'h8E, 8'hF2, 1, 16'h0000, ok);
    chk({15'h0, ok}, 16'h0001);
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    t_defaults();
    t_addr();
    t_proc();
    t_wake();
    t_strap();
    t_soft();
    conclude();
  end

  // The scenarios need about 14000 cycles; this leaves ample margin.
  initial begin
    repeat (60000) @(posedge core_clk);
    num_errors++;
    conclude();
  end
endmodule // testbench
